// ==== rtl/cpurs_core_regs.sv ====
// programmer-visible register set with stack sequencing and wishbone view
// What this block does
// - eight-bit accumulator for operands and results
// - eight-bit index register for addressing and data
// - thirteen-bit program counter over 8192 bytes
// - stack pointer page bits fixed at 0000011
// - resets and stack instruction load stack top
// - stack wraps to top after 64 pushes
// - call uses two bytes, interrupt five
// - push decrements, low byte first, pulls reversed
// - five-bit condition codes, individually testable
// - half carry from bit 3 on add
// - mask flag blocks interrupt service
// - external request held pending while masked
// - withdrawn internal request may be lost
// - negative flag copies result bit 7
// - zero flag set on zero result
// - carry from alu, bit test, shifts
`timescale 1ns/100ps
`include "cpurs_cfg.svh"
module cpurs_core_regs (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire cpurs_pkg::cpurs_op_e OP,
  input  wire logic [7:0]           DIN,
  input  wire logic [7:0]           ALU_RES,
  input  wire logic                 ALU_C,
  input  wire logic [12:0]          ADDR_IN,
  input  wire logic                 EXT_IRQ_N,
  input  wire logic                 INT_IRQ,
  input  wire logic [7:0]           STACK_RDATA,
  output logic [7:0]                ACCUMULATOR,
  output logic [7:0]                INDEX_REG,
  output logic [12:0]               PROGRAM_COUNTER,
  output logic [12:0]               STACK_POINTER,
  output logic [4:0]                CONDITION_CODE_REG,
  output logic [12:0]               STACK_ADDR,
  output logic [7:0]                STACK_WDATA,
  output logic                      STACK_WE,
  output logic                      STACK_RE,
  output logic                      BUSY,
  output logic                      IRQ_REQ,
  output logic                      IRQ_EXT_SEL,
  input  wire logic                 WB_CYC_I,
  input  wire logic                 WB_STB_I,
  input  wire logic                 WB_WE_I,
  input  wire logic [7:0]           WB_ADR_I,
  input  wire logic [3:0]           WB_SEL_I,
  input  wire logic [31:0]          WB_DAT_I,
  output logic [31:0]               WB_DAT_O,
  output logic                      WB_ACK_O
);
  import cpurs_pkg::*;

  function automatic logic cpurs_half(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return s[4];
  endfunction

  function automatic logic [1:0] cpurs_nz(input logic [7:0] v);
    return {v[7], v == 8'h00};
  endfunction

  cpurs_state_e state_ff, nxt_state;
  logic [7:0]   acc_ff, nxt_acc;
  logic [7:0]   index_ff, nxt_index;
  logic [12:0]  program_counter_ff, nxt_program_counter;
  logic [5:0]   stack_pointer_ff, nxt_stack_pointer;
  logic [4:0]   ccr_ff, nxt_ccr;
  logic [2:0]   step_ff, nxt_step;
  logic [2:0]   last_ff, nxt_last;
  logic [12:0]  saddr_ff, nxt_saddr;
  logic [7:0]   swdata_ff, nxt_swdata;
  logic         swe_ff, nxt_swe;
  logic         sre_ff, nxt_sre;
  logic [2:0]   re_step_ff, nxt_re_step;
  logic         cap_ff, nxt_cap;
  logic [2:0]   cap_step_ff, nxt_cap_step;
  logic         busy_ff, nxt_busy;
  cpurs_op_e    op_take;
  logic [8:0]   sum;
  logic         cin;
  logic         wb_wr;
  logic [5:0]   sp_inc;

  assign op_take = (state_ff == ST_IDLE) ? OP : OP_NOP;
  // a write lands on the edge at which the master sees ack high
  assign wb_wr   = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;
  assign sp_inc  = stack_pointer_ff + 6'h01;

  always_comb begin
    nxt_state           = state_ff;
    nxt_acc             = acc_ff;
    nxt_index           = index_ff;
    nxt_program_counter = program_counter_ff;
    nxt_stack_pointer   = stack_pointer_ff;
    nxt_ccr             = ccr_ff;
    nxt_step            = step_ff;
    nxt_last            = last_ff;
    nxt_saddr           = saddr_ff;
    nxt_swdata          = swdata_ff;
    nxt_swe             = 1'b0;
    nxt_sre             = 1'b0;
    nxt_re_step         = re_step_ff;
    nxt_cap             = sre_ff;
    nxt_cap_step        = re_step_ff;
    cin                 = (op_take == OP_ADC) & ccr_ff[`CPURS_CC_C];
    sum                 = {1'b0, acc_ff} + {1'b0, DIN} + {8'h00, cin};
    // software loads lose to the sequencer in the same cycle
    if (wb_wr && WB_SEL_I[0]) begin
      case (WB_ADR_I)
        `CPURS_OFF_ACC:   nxt_acc = WB_DAT_I[7:0];
        `CPURS_OFF_INDEX: nxt_index = WB_DAT_I[7:0];
        `CPURS_OFF_PC: begin
          nxt_program_counter[7:0] = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) begin
            nxt_program_counter[12:8] = WB_DAT_I[12:8];
          end
        end
        `CPURS_OFF_CCR:   nxt_ccr = WB_DAT_I[4:0];
        default: ;
      endcase
    end
    // pulled byte lands in the register its step names
    if (cap_ff) begin
      case (cap_step_ff)
        3'h0:    nxt_program_counter[7:0] = STACK_RDATA;
        3'h1:    nxt_program_counter[12:8] = STACK_RDATA[4:0];
        3'h2:    nxt_index = STACK_RDATA;
        3'h3:    nxt_acc = STACK_RDATA;
        default: nxt_ccr = STACK_RDATA[4:0];
      endcase
    end
    unique case (state_ff)
      ST_IDLE: begin
        case (op_take)
          OP_LDA: begin
            nxt_acc = DIN;
            nxt_ccr[`CPURS_CC_N:`CPURS_CC_Z] = cpurs_nz(DIN);
          end
          OP_LDX: begin
            nxt_index = DIN;
            nxt_ccr[`CPURS_CC_N:`CPURS_CC_Z] = cpurs_nz(DIN);
          end
          OP_ADD, OP_ADC: begin
            nxt_acc = sum[7:0];
            nxt_ccr[`CPURS_CC_H] = cpurs_half(acc_ff, DIN, cin);
            nxt_ccr[`CPURS_CC_N:`CPURS_CC_Z] = cpurs_nz(sum[7:0]);
            nxt_ccr[`CPURS_CC_C] = sum[8];
          end
          OP_LOGA: begin
            nxt_acc = ALU_RES;
            nxt_ccr[`CPURS_CC_N:`CPURS_CC_Z] = cpurs_nz(ALU_RES);
          end
          OP_SHA: begin
            nxt_acc = ALU_RES;
            nxt_ccr[`CPURS_CC_N:`CPURS_CC_Z] = cpurs_nz(ALU_RES);
            nxt_ccr[`CPURS_CC_C] = ALU_C;
          end
          OP_SHX: begin
            nxt_index = ALU_RES;
            nxt_ccr[`CPURS_CC_N:`CPURS_CC_Z] = cpurs_nz(ALU_RES);
            nxt_ccr[`CPURS_CC_C] = ALU_C;
          end
          OP_BTB: nxt_ccr[`CPURS_CC_C] = ALU_C;
          OP_JMP: nxt_program_counter = ADDR_IN;
          OP_INC: nxt_program_counter = program_counter_ff + 13'h0001;
          OP_CALL: begin
            nxt_state = ST_PUSH;
            nxt_step  = 3'h0;
            nxt_last  = `CPURS_CALL_LAST;
          end
          OP_INTE: begin
            nxt_state = ST_PUSH;
            nxt_step  = 3'h0;
            nxt_last  = `CPURS_INT_LAST;
          end
          OP_RTS: begin
            nxt_state = ST_PULL;
            nxt_step  = `CPURS_RTS_FIRST;
          end
          OP_RTI: begin
            nxt_state = ST_PULL;
            nxt_step  = `CPURS_RTI_FIRST;
          end
          OP_RESET_STACK: nxt_stack_pointer = `CPURS_SP_TOP;
          OP_SEI: nxt_ccr[`CPURS_CC_I] = 1'b1;
          OP_CLI: nxt_ccr[`CPURS_CC_I] = 1'b0;
          default: ;
        endcase
      end
      ST_PUSH: begin
        nxt_swe   = 1'b1;
        nxt_saddr = {`CPURS_SP_PAGE, stack_pointer_ff};
        case (step_ff)
          3'h0:    nxt_swdata = program_counter_ff[7:0];
          3'h1:    nxt_swdata = {3'h0, program_counter_ff[12:8]};
          3'h2:    nxt_swdata = index_ff;
          3'h3:    nxt_swdata = acc_ff;
          default: begin
            // mask rises only once the old flags are stacked, so return restores them
            nxt_swdata = {3'h0, ccr_ff};
            nxt_ccr[`CPURS_CC_I] = 1'b1;
          end
        endcase
        // six-bit count wraps from the page bottom back to the top
        nxt_stack_pointer = stack_pointer_ff - 6'h01;
        if (step_ff == last_ff) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_step = step_ff + 3'h1;
        end
      end
      ST_PULL: begin
        nxt_sre           = 1'b1;
        nxt_saddr         = {`CPURS_SP_PAGE, sp_inc};
        nxt_re_step       = step_ff;
        nxt_stack_pointer = sp_inc;
        if (step_ff == 3'h0) begin
          nxt_state = ST_DRAIN;
        end else begin
          nxt_step = step_ff - 3'h1;
        end
      end
      ST_DRAIN: begin
        if (!sre_ff && !cap_ff) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
    nxt_busy = (nxt_state != ST_IDLE);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff           <= ST_IDLE;
      acc_ff             <= 8'h00;
      index_ff           <= 8'h00;
      program_counter_ff <= `CPURS_PC_RST;
      stack_pointer_ff   <= `CPURS_SP_TOP;
      ccr_ff             <= `CPURS_CC_RST;
      step_ff            <= 3'h0;
      last_ff            <= 3'h0;
      saddr_ff           <= 13'h0000;
      swdata_ff          <= 8'h00;
      swe_ff             <= 1'b0;
      sre_ff             <= 1'b0;
      re_step_ff         <= 3'h0;
      cap_ff             <= 1'b0;
      cap_step_ff        <= 3'h0;
      busy_ff            <= 1'b0;
    end else begin
      state_ff           <= nxt_state;
      acc_ff             <= nxt_acc;
      index_ff           <= nxt_index;
      program_counter_ff <= nxt_program_counter;
      stack_pointer_ff   <= nxt_stack_pointer;
      ccr_ff             <= nxt_ccr;
      step_ff            <= nxt_step;
      last_ff            <= nxt_last;
      saddr_ff           <= nxt_saddr;
      swdata_ff          <= nxt_swdata;
      swe_ff             <= nxt_swe;
      sre_ff             <= nxt_sre;
      re_step_ff         <= nxt_re_step;
      cap_ff             <= nxt_cap;
      cap_step_ff        <= nxt_cap_step;
      busy_ff            <= nxt_busy;
    end
  end

  // interrupt request: external pin is latched, internal level is not
  logic ext_s1_ff, ext_s2_ff, ext_d_ff, pend_ff, req_ff, sel_ff;
  logic nxt_pend, nxt_req, nxt_sel;

  always_comb begin
    nxt_pend = pend_ff;
    if (op_take == OP_INTE && sel_ff) begin
      nxt_pend = 1'b0;
    end
    if (ext_d_ff && !ext_s2_ff) begin
      nxt_pend = 1'b1;
    end
    nxt_req = ~ccr_ff[`CPURS_CC_I] & (pend_ff | INT_IRQ);
    nxt_sel = pend_ff;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_s1_ff <= 1'b1;
      ext_s2_ff <= 1'b1;
      ext_d_ff  <= 1'b1;
      pend_ff   <= 1'b0;
      req_ff    <= 1'b0;
      sel_ff    <= 1'b0;
    end else begin
      ext_s1_ff <= EXT_IRQ_N;
      ext_s2_ff <= ext_s1_ff;
      ext_d_ff  <= ext_s2_ff;
      pend_ff   <= nxt_pend;
      req_ff    <= nxt_req;
      sel_ff    <= nxt_sel;
    end
  end

  // wishbone slave: ack one cycle after the strobe, unmapped reads zero
  logic        ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;

  always_comb begin
    nxt_ack  = WB_CYC_I & WB_STB_I & ~ack_ff;
    nxt_rdat = 32'h0000_0000;
    case (WB_ADR_I)
      `CPURS_OFF_ACC:   nxt_rdat[7:0] = acc_ff;
      `CPURS_OFF_INDEX: nxt_rdat[7:0] = index_ff;
      `CPURS_OFF_PC:    nxt_rdat[12:0] = program_counter_ff;
      `CPURS_OFF_SP:    nxt_rdat[12:0] = {`CPURS_SP_PAGE, stack_pointer_ff};
      `CPURS_OFF_CCR:   nxt_rdat[4:0] = ccr_ff;
      `CPURS_OFF_STAT:  nxt_rdat[2:0] = {req_ff, pend_ff, busy_ff};
      default: ;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign ACCUMULATOR        = acc_ff;
  assign INDEX_REG          = index_ff;
  assign PROGRAM_COUNTER    = program_counter_ff;
  assign STACK_POINTER      = {`CPURS_SP_PAGE, stack_pointer_ff};
  assign CONDITION_CODE_REG = ccr_ff;
  assign STACK_ADDR         = saddr_ff;
  assign STACK_WDATA        = swdata_ff;
  assign STACK_WE           = swe_ff;
  assign STACK_RE           = sre_ff;
  assign BUSY               = busy_ff;
  assign IRQ_REQ            = req_ff;
  assign IRQ_EXT_SEL        = sel_ff;
  assign WB_DAT_O           = rdat_ff;
  assign WB_ACK_O           = ack_ff;

  property p_stack_page;
    @(posedge CLK) disable iff (!RST_N)
      (STACK_WE || STACK_RE) |-> STACK_ADDR[12:6] == `CPURS_SP_PAGE;
  endproperty
  a_stack_page: assert property (p_stack_page) else $error("stack address off page");

  property p_call_two;
    @(posedge CLK) disable iff (!RST_N)
      op_take == OP_CALL |-> ##3 stack_pointer_ff == $past(stack_pointer_ff, 3) - 6'h02;
  endproperty
  a_call_two: assert property (p_call_two) else $error("call did not use two bytes");

  property p_int_five;
    @(posedge CLK) disable iff (!RST_N)
      op_take == OP_INTE |-> ##6 (stack_pointer_ff == $past(stack_pointer_ff, 6) - 6'h05)
        && ccr_ff[`CPURS_CC_I];
  endproperty
  a_int_five: assert property (p_int_five) else $error("interrupt entry wrong");

  property p_low_first;
    @(posedge CLK) disable iff (!RST_N)
      op_take == OP_INTE |-> ##2 STACK_WE && STACK_WDATA == $past(program_counter_ff[7:0], 2)
        ##1 STACK_WE && STACK_ADDR == $past(STACK_ADDR) - 13'h0001;
  endproperty
  a_low_first: assert property (p_low_first) else $error("push order wrong");

  property p_reset_stack;
    @(posedge CLK) disable iff (!RST_N)
      op_take == OP_RESET_STACK |=> STACK_POINTER == {`CPURS_SP_PAGE, `CPURS_SP_TOP};
  endproperty
  a_reset_stack: assert property (p_reset_stack) else $error("stack not at top");

  property p_half;
    @(posedge CLK) disable iff (!RST_N)
      op_take == OP_ADD |=>
        ccr_ff[`CPURS_CC_H] == cpurs_half($past(acc_ff), $past(DIN), 1'b0);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");

  property p_nz;
    @(posedge CLK) disable iff (!RST_N)
      op_take == OP_LDA |=> ccr_ff[`CPURS_CC_N] == acc_ff[7]
        && ccr_ff[`CPURS_CC_Z] == (acc_ff == 8'h00);
  endproperty
  a_nz: assert property (p_nz) else $error("n or z flag wrong");

  property p_masked;
    @(posedge CLK) disable iff (!RST_N)
      IRQ_REQ |-> !$past(ccr_ff[`CPURS_CC_I]);
  endproperty
  a_masked: assert property (p_masked) else $error("request while masked");

  property p_ext_held;
    @(posedge CLK) disable iff (!RST_N)
      (ext_d_ff && !ext_s2_ff) |=> pend_ff;
  endproperty
  a_ext_held: assert property (p_ext_held) else $error("external request lost");

  c_call: cover property (@(posedge CLK) disable iff (!RST_N) op_take == OP_CALL);
  c_rti: cover property (@(posedge CLK) disable iff (!RST_N)
    state_ff == ST_DRAIN ##1 state_ff == ST_IDLE);
  c_wrap: cover property (@(posedge CLK) disable iff (!RST_N)
    STACK_WE && STACK_ADDR[5:0] == 6'h00 ##1 stack_pointer_ff == `CPURS_SP_TOP);
endmodule

// ==== rtl/cpurs_cfg.svh ====
// constants of the cpu register set: offsets, field positions, reset values
`ifndef CPURS_CFG_SVH
`define CPURS_CFG_SVH
`define CPURS_ACC_W      8
`define CPURS_PC_W       13
`define CPURS_SPLO_W     6
`define CPURS_CC_W       5
`define CPURS_SP_PAGE    7'h03
`define CPURS_SP_TOP     6'h3f
`define CPURS_PC_RST     13'h0000
`define CPURS_CC_RST     5'h08
`define CPURS_CC_H       4
`define CPURS_CC_I       3
`define CPURS_CC_N       2
`define CPURS_CC_Z       1
`define CPURS_CC_C       0
`define CPURS_CALL_LAST  3'h1
`define CPURS_INT_LAST   3'h4
`define CPURS_RTS_FIRST  3'h1
`define CPURS_RTI_FIRST  3'h4
`define CPURS_OFF_ACC    8'h00
`define CPURS_OFF_INDEX  8'h04
`define CPURS_OFF_PC     8'h08
`define CPURS_OFF_SP     8'h0c
`define CPURS_OFF_CCR    8'h10
`define CPURS_OFF_STAT   8'h14
`endif

// ==== rtl/cpurs_pkg.sv ====
// types shared by the cpu register set
package cpurs_pkg;
  typedef enum logic [4:0] {
    OP_NOP         = 5'h00,
    OP_LDA         = 5'h01,
    OP_LDX         = 5'h02,
    OP_ADD         = 5'h03,
    OP_ADC         = 5'h04,
    OP_LOGA        = 5'h05,
    OP_SHA         = 5'h06,
    OP_SHX         = 5'h07,
    OP_BTB         = 5'h08,
    OP_JMP         = 5'h09,
    OP_INC         = 5'h0a,
    OP_CALL        = 5'h0b,
    OP_INTE        = 5'h0c,
    OP_RTS         = 5'h0d,
    OP_RTI         = 5'h0e,
    OP_RESET_STACK = 5'h0f,
    OP_SEI         = 5'h10,
    OP_CLI         = 5'h11
  } cpurs_op_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PUSH  = 2'b01,
    ST_PULL  = 2'b10,
    ST_DRAIN = 2'b11
  } cpurs_state_e;
endpackage

// ==== dv/cpurs_stack_model.sv ====
// stack ram model that answers the register set's stack strobes
`timescale 1ns/100ps
module cpurs_stack_model (
  input  wire logic        CLK,
  input  wire logic [12:0] STACK_ADDR,
  input  wire logic [7:0]  STACK_WDATA,
  input  wire logic        STACK_WE,
  input  wire logic        STACK_RE,
  output logic [7:0]       STACK_RDATA
);
  logic [7:0] mem [64];

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'h00;
    end
    STACK_RDATA = 8'h00;
  end

  // data stands only in the cycle after a read, then inverts each cycle, so a stale byte comes back inverted only an odd number of cycles late
  always @(posedge CLK) begin
    if (STACK_WE) begin
      mem[STACK_ADDR[5:0]] <= STACK_WDATA;
    end
    if (STACK_RE) begin
      STACK_RDATA <= mem[STACK_ADDR[5:0]];
    end else begin
      STACK_RDATA <= ~STACK_RDATA;
    end
  end
endmodule

// ==== dv/cpurs_core_regs_tb_top.sv ====
// self-checking bench of the cpu register set against a reference model
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpurs_core_regs_tb_top;
  import cpurs_pkg::*;
  logic        CLK, RST_N, ALU_C, EXT_IRQ_N, INT_IRQ, STACK_WE, STACK_RE;
  logic        BUSY, IRQ_REQ, IRQ_EXT_SEL, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  cpurs_op_e   OP;
  logic [7:0]  DIN, ALU_RES, STACK_RDATA, ACCUMULATOR, INDEX_REG, STACK_WDATA, WB_ADR_I;
  logic [12:0] ADDR_IN, PROGRAM_COUNTER, STACK_POINTER, STACK_ADDR;
  logic [4:0]  CONDITION_CODE_REG;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd, rv, ri;
  logic [7:0]  m_a, m_x;
  logic [7:0]  m_mem [64];
  logic [12:0] m_pc;
  logic [5:0]  m_sp;
  logic [4:0]  m_cc;
  int          errors, check_count;
  integer      seed;
  cpurs_op_e   ops [17] = '{OP_LDA, OP_LDX, OP_ADD, OP_ADC, OP_SHA, OP_SHX, OP_BTB, OP_JMP,
                            OP_SEI, OP_CLI, OP_CALL, OP_INTE, OP_RTS, OP_RTI, OP_RESET_STACK,
                            OP_LOGA, OP_INC};

  cpurs_core_regs i_cpurs_core_regs (
    .CLK(CLK), .RST_N(RST_N), .OP(OP), .DIN(DIN), .ALU_RES(ALU_RES), .ALU_C(ALU_C),
    .ADDR_IN(ADDR_IN), .EXT_IRQ_N(EXT_IRQ_N), .INT_IRQ(INT_IRQ), .STACK_RDATA(STACK_RDATA),
    .ACCUMULATOR(ACCUMULATOR), .INDEX_REG(INDEX_REG), .PROGRAM_COUNTER(PROGRAM_COUNTER),
    .STACK_POINTER(STACK_POINTER), .CONDITION_CODE_REG(CONDITION_CODE_REG),
    .STACK_ADDR(STACK_ADDR), .STACK_WDATA(STACK_WDATA), .STACK_WE(STACK_WE),
    .STACK_RE(STACK_RE), .BUSY(BUSY), .IRQ_REQ(IRQ_REQ), .IRQ_EXT_SEL(IRQ_EXT_SEL),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O)
  );

  cpurs_stack_model i_cpurs_stack_model (
    .CLK(CLK), .STACK_ADDR(STACK_ADDR), .STACK_WDATA(STACK_WDATA), .STACK_WE(STACK_WE),
    .STACK_RE(STACK_RE), .STACK_RDATA(STACK_RDATA)
  );

  always #5 CLK = ~CLK;

  always @(negedge CLK) begin
    if (STACK_WE === 1'b1 || STACK_RE === 1'b1) begin
      `CHK(STACK_ADDR[12:6], 7'h03)
    end
  end

  task automatic test_done();
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic hung();
    errors++;
    test_done();
  endtask

  task automatic push(input logic [7:0] v);
    m_mem[m_sp] = v;
    m_sp = m_sp - 6'h01;
  endtask

  task automatic pull(output logic [7:0] v);
    m_sp = m_sp + 6'h01;
    v = m_mem[m_sp];
  endtask

  task automatic nz(input logic [7:0] v);
    m_cc[2] = v[7];
    m_cc[1] = (v == 8'h00);
  endtask

  task automatic model(input cpurs_op_e op, input logic [7:0] d, input logic [7:0] r,
                       input logic c, input logic [12:0] ad);
    logic [8:0] s;
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ci;
    ci = (op == OP_ADC) & m_cc[0];
    case (op)
      OP_LDA: begin
        m_a = d;
        nz(d);
      end
      OP_LDX: begin
        m_x = d;
        nz(d);
      end
      OP_ADD, OP_ADC: begin
        s = {1'b0, m_a} + {1'b0, d} + {8'h00, ci};
        m_cc[4] = ({1'b0, m_a[3:0]} + {1'b0, d[3:0]} + {4'h0, ci}) > 5'h0f;
        m_cc[0] = s[8];
        m_a = s[7:0];
        nz(m_a);
      end
      OP_SHA, OP_SHX: begin
        if (op == OP_SHA) m_a = r;
        else m_x = r;
        m_cc[0] = c;
        nz(r);
      end
      OP_BTB: m_cc[0] = c;
      OP_LOGA: begin
        m_a = r;
        nz(r);
      end
      OP_INC: m_pc = m_pc + 13'h0001;
      OP_JMP: m_pc = ad;
      OP_SEI: m_cc[3] = 1'b1;
      OP_CLI: m_cc[3] = 1'b0;
      OP_RESET_STACK: m_sp = 6'h3f;
      OP_CALL, OP_INTE: begin
        push(m_pc[7:0]);
        push({3'h0, m_pc[12:8]});
        if (op == OP_INTE) begin
          push(m_x);
          push(m_a);
          push({3'h0, m_cc});
          m_cc[3] = 1'b1;
        end
      end
      OP_RTS, OP_RTI: begin
        if (op == OP_RTI) begin
          pull(lo);
          m_cc = lo[4:0];
          pull(m_a);
          pull(m_x);
        end
        pull(hi);
        pull(lo);
        m_pc = {hi[4:0], lo};
      end
      default: ;
    endcase
  endtask

  task automatic check_regs();
    `CHK(ACCUMULATOR, m_a)
    `CHK(INDEX_REG, m_x)
    `CHK(PROGRAM_COUNTER, m_pc)
    `CHK(STACK_POINTER, {7'h03, m_sp})
    `CHK(CONDITION_CODE_REG, m_cc)
    for (int i = 0; i < 64; i++) `CHK(i_cpurs_stack_model.mem[i], m_mem[i])
  endtask

  task automatic do_op(input cpurs_op_e op, input logic [31:0] v);
    int k;
    @(posedge CLK);
    OP <= op;
    DIN <= v[7:0];
    ALU_RES <= v[15:8];
    ALU_C <= v[16];
    ADDR_IN <= v[29:17];
    @(posedge CLK);
    OP <= OP_NOP;
    model(op, v[7:0], v[15:8], v[16], v[29:17]);
    repeat (2) @(negedge CLK);
    for (k = 0; k < 20 && BUSY !== 1'b0; k++) @(negedge CLK);
    if (k == 20) hung();
    // the last stack write lands in the ram one edge after busy falls
    @(negedge CLK);
    check_regs();
  endtask

  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] wd);
    int k;
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= ad;
    WB_DAT_I <= wd;
    // ack and read data are taken at the rising edge, before that edge's update lands
    for (k = 0; k < 20; k++) begin
      @(posedge CLK);
      if (WB_ACK_O === 1'b1) break;
    end
    if (k == 20) hung();
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask

  initial begin
    seed = 32'h78e4;
    {CLK, RST_N, ALU_C, INT_IRQ, WB_CYC_I, WB_STB_I, WB_WE_I} = 7'h00;
    EXT_IRQ_N = 1'b1;
    OP = OP_NOP;
    {DIN, ALU_RES, ADDR_IN, WB_ADR_I, WB_DAT_I} = 69'h0;
    WB_SEL_I = 4'hf;
    {errors, check_count} = 64'h0;
    {m_a, m_x, m_pc, m_sp, m_cc} = {29'h0, 6'h3f, 5'h08};
    for (int i = 0; i < 64; i++) m_mem[i] = 8'h00;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    check_regs();
    // masked requests: external one must survive, withdrawn internal one may vanish
    @(posedge CLK);
    EXT_IRQ_N <= 1'b0;
    INT_IRQ <= 1'b1;
    repeat (3) @(posedge CLK);
    EXT_IRQ_N <= 1'b1;
    INT_IRQ <= 1'b0;
    repeat (4) @(negedge CLK);
    `CHK(IRQ_REQ, 1'b0)
    do_op(OP_CLI, 32'h0);
    repeat (2) @(negedge CLK);
    `CHK(IRQ_REQ, 1'b1)
    `CHK(IRQ_EXT_SEL, 1'b1)
    do_op(OP_JMP, 32'h3578_0000);
    do_op(OP_INTE, 32'h0);
    repeat (2) @(negedge CLK);
    `CHK(IRQ_REQ, 1'b0)
    `CHK(IRQ_EXT_SEL, 1'b0)
    do_op(OP_RTI, 32'h0);
    repeat (2) @(negedge CLK);
    `CHK(IRQ_REQ, 1'b0)
    @(posedge CLK);
    INT_IRQ <= 1'b1;
    repeat (3) @(negedge CLK);
    `CHK(IRQ_REQ, 1'b1)
    @(posedge CLK);
    INT_IRQ <= 1'b0;
    // register bus: read-only stack pointer, unmapped place, read back
    wb(1'b1, 8'h0c, 32'h0000_1234);
    wb(1'b0, 8'h0c, 32'h0);
    `CHK(rd[12:0], {7'h03, m_sp})
    wb(1'b1, 8'h00, 32'h0000_005a);
    wb(1'b1, 8'h04, 32'h0000_00c3);
    m_a = 8'h5a;
    m_x = 8'hc3;
    wb(1'b1, 8'h40, 32'h0000_00ff);
    wb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, 8'h04, 32'h0);
    `CHK(rd[7:0], m_x)
    wb(1'b0, 8'h10, 32'h0);
    `CHK(rd[4:0], m_cc)
    check_regs();
    for (int n = 0; n < 300; n++) begin
      rv = $random(seed);
      ri = $random(seed);
      do_op(ops[ri % 17], rv);
    end
    // 33 nested calls overrun the 64-byte page and wrap
    do_op(OP_RESET_STACK, 32'h0);
    for (int n = 0; n < 33; n++) begin
      rv = $random(seed);
      do_op(OP_JMP, rv);
      do_op(OP_CALL, rv);
    end
    `CHK(STACK_POINTER, 13'h00fd)
    test_done();
  end
endmodule
